// File: logic/dglsc_consts.svh
// Purpose: Offsets, field positions and reset values of the global load
//          and sequencer control block
// Assumes: 32-bit APB, one word per register
// Notes: Definitions only
`ifndef DGLSC_CONSTS_SVH
`define DGLSC_CONSTS_SVH
`define DGLSC_UNITS 8
`define DGLSC_ADDR_W 12
`define DGLSC_OFS_UPD_REQ 12'h084
`define DGLSC_OFS_GCTRL 12'h088
`define DGLSC_OFS_GSTAT 12'h08c
`define DGLSC_OFS_IRQ_STS 12'h0a0
`define DGLSC_OFS_IRQ_EN 12'h0a4
`define DGLSC_OFS_IRQ_CLR 12'h0a8
`define DGLSC_GCTRL_GATE_BIT 8
`define DGLSC_GCTRL_W 9
`define DGLSC_BUSY_STRIDE 4
`define DGLSC_IRQ_W 16
`define DGLSC_RST_UPD 8'h00
`define DGLSC_RST_GCTRL 9'h000
`define DGLSC_RST_IRQ 16'h0000
`endif

// File: logic/dglsc_ctrl.sv
// Purpose: Update-request and global control registers for eight units
// Assumes: Unit-side inputs come from logic on pclk; APB zero-wait slave
// Notes: Global status and interrupt registers sit beside the two
//        documented ones
//
// Functional notes
// - Eight reset-zero read/write update request bits
// - Data-space writes forwarded to unit one cycle later
// - Update after data moved; bit self-clears
// - Global-mode units update together when all ready
// - Control bits 31:9 reserved, written zero
// - Bit 8 gates every interrupt source
// - Bits 7:0 run or stop each sequencer
// - Running sequencer holds unit busy set
// - Busy on transfer, pending update or run
`include "dglsc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dglsc_ctrl
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`DGLSC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] unit_manual_mode,
   input wire logic [7:0] unit_global_mode,
   input wire logic [7:0] unit_data_pending,
   input wire logic [7:0] unit_xfer_active,
   input wire logic [7:0] data_space_wr,
   output logic [7:0] unit_update,
   output logic [7:0] unit_forward,
   output logic [7:0] seq_run,
   output logic [7:0] unit_busy,
   output logic irq
);
   logic [7:0] upd_req_reg, upd_req_next;
   logic [`DGLSC_GCTRL_W-1:0] gctrl_reg, gctrl_next;
   dglsc_pkg::dglsc_seq_t seq_reg [8];
   dglsc_pkg::dglsc_seq_t seq_next [8];
   logic [7:0] seq_run_reg, seq_run_next;
   logic [7:0] busy_reg, busy_next;
   logic [7:0] upd_reg, upd_next;
   logic [7:0] fwd_reg, fwd_next;
   logic [`DGLSC_IRQ_W-1:0] sts_reg, sts_next, en_reg, en_next;
   logic irq_reg, irq_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pslverr_reg, pslverr_next;
   logic wr, setup;
   logic [7:0] ready, fire, halt, gsel;
   logic grp_ok;
   logic [31:0] gstat;
   logic [7:0] pwdata_q;

   // Zero-wait slave: pready rises after reset and stays high
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite && pready_reg;

   // Update scheduling
   always_comb
   begin
      gsel = unit_manual_mode & unit_global_mode;
      ready = upd_req_reg & unit_manual_mode & ~unit_data_pending
         & ~unit_xfer_active;
      grp_ok = &(~gsel | ready);
      for (int i = 0; i < 8; i++)
      begin
         fire[i] = ready[i] && (!gsel[i] || grp_ok);
      end
   end

   // Request and control registers
   always_comb
   begin
      upd_req_next = upd_req_reg;
      gctrl_next = gctrl_reg;
      en_next = en_reg;
      for (int i = 0; i < 8; i++)
      begin
         // Non-manual units ignore requests, so a stray bit drains
         if (fire[i] || !unit_manual_mode[i])
         begin
            upd_req_next[i] = 1'b0;
         end
      end
      if (wr)
      begin
         // A write lands after the self-clear, so a fresh set wins
         case (paddr)
            `DGLSC_OFS_UPD_REQ: upd_req_next = pwdata[7:0];
            `DGLSC_OFS_GCTRL:
               gctrl_next = pwdata[`DGLSC_GCTRL_W-1:0];
            `DGLSC_OFS_IRQ_EN: en_next = pwdata[`DGLSC_IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Sequencers
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         seq_next[i] = seq_reg[i];
         halt[i] = 1'b0;
         case (seq_reg[i])
            dglsc_pkg::DGLSC_SEQ_IDLE:
               if (gctrl_reg[i])
               begin
                  seq_next[i] = dglsc_pkg::DGLSC_SEQ_RUN;
               end
            dglsc_pkg::DGLSC_SEQ_RUN:
               // A transfer in flight delays the halt
               if (!gctrl_reg[i] && !unit_xfer_active[i])
               begin
                  seq_next[i] = dglsc_pkg::DGLSC_SEQ_IDLE;
                  halt[i] = 1'b1;
               end
            default: seq_next[i] = dglsc_pkg::DGLSC_SEQ_IDLE;
         endcase
         seq_run_next[i] = (seq_next[i] == dglsc_pkg::DGLSC_SEQ_RUN);
      end
      busy_next = unit_xfer_active | upd_req_next | seq_run_next;
      upd_next = fire;
      fwd_next = data_space_wr;
   end

   // Interrupts and read data
   always_comb
   begin
      sts_next = sts_reg;
      if (wr && paddr == `DGLSC_OFS_IRQ_CLR)
      begin
         sts_next = sts_reg & ~pwdata[`DGLSC_IRQ_W-1:0];
      end
      sts_next = sts_next | {halt, fire};
      irq_next = gctrl_reg[`DGLSC_GCTRL_GATE_BIT]
         && |(sts_reg & en_reg);
      gstat = 32'h0000_0000;
      for (int i = 0; i < 8; i++)
      begin
         gstat[i*`DGLSC_BUSY_STRIDE] = busy_reg[i];
      end
      prdata_next = prdata_reg;
      pslverr_next = 1'b0;
      if (setup)
      begin
         prdata_next = 32'h0000_0000;
         case (paddr)
            `DGLSC_OFS_UPD_REQ: prdata_next[7:0] = upd_req_reg;
            `DGLSC_OFS_GCTRL:
               prdata_next[`DGLSC_GCTRL_W-1:0] = gctrl_reg;
            `DGLSC_OFS_GSTAT: prdata_next = gstat;
            `DGLSC_OFS_IRQ_STS: prdata_next[`DGLSC_IRQ_W-1:0] = sts_reg;
            `DGLSC_OFS_IRQ_EN: prdata_next[`DGLSC_IRQ_W-1:0] = en_reg;
            `DGLSC_OFS_IRQ_CLR: ;
            default: pslverr_next = 1'b1;
         endcase
      end
      else if (!psel)
      begin
         pslverr_next = 1'b0;
      end
      else
      begin
         pslverr_next = pslverr_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         upd_req_reg <= `DGLSC_RST_UPD;
         gctrl_reg <= `DGLSC_RST_GCTRL;
         for (int i = 0; i < 8; i++)
         begin
            seq_reg[i] <= dglsc_pkg::DGLSC_SEQ_IDLE;
         end
         seq_run_reg <= 8'h00;
         busy_reg <= 8'h00;
         upd_reg <= 8'h00;
         fwd_reg <= 8'h00;
         sts_reg <= `DGLSC_RST_IRQ;
         en_reg <= `DGLSC_RST_IRQ;
         irq_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else if (ce)
      begin
         upd_req_reg <= upd_req_next;
         gctrl_reg <= gctrl_next;
         seq_reg <= seq_next;
         seq_run_reg <= seq_run_next;
         busy_reg <= busy_next;
         upd_reg <= upd_next;
         fwd_reg <= fwd_next;
         sts_reg <= sts_next;
         en_reg <= en_next;
         irq_reg <= irq_next;
         prdata_reg <= prdata_next;
         pready_reg <= 1'b1;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign unit_update = upd_reg;
   assign unit_forward = fwd_reg;
   assign seq_run = seq_run_reg;
   assign unit_busy = busy_reg;
   assign irq = irq_reg;

   default clocking dglsc_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn || !ce);

   upd_self_clear_a: assert property (
      fire != 8'h00 && !wr |=> (upd_req_reg & $past(fire)) == 8'h00
         && unit_update == $past(fire))
      else $error("request bit did not clear at update");
   upd_data_idle_a: assert property (
      unit_update != 8'h00 |->
         ($past(unit_data_pending | unit_xfer_active) & unit_update) == 8'h00)
      else $error("update while data still moving");
   group_together_a: assert property (
      (unit_update & $past(gsel)) != 8'h00 |->
         (unit_update & $past(gsel)) == $past(gsel))
      else $error("global-mode units updated apart");
   busy_while_run_a: assert property (
      seq_run[0] ##1 seq_run[0] |-> unit_busy[0])
      else $error("busy dropped while sequencer runs");
   start_lockstep_a: assert property (
      wr && paddr == `DGLSC_OFS_GCTRL && seq_run == 8'h00 |->
         ##2 seq_run == $past(pwdata[7:0], 2))
      else $error("sequencers did not start together");
   irq_gate_a: assert property (
      !gctrl_reg[`DGLSC_GCTRL_GATE_BIT] |=> !irq)
      else $error("interrupt passed a closed gate");
   halt_wait_a: assert property (
      seq_run[0] && unit_xfer_active[0] |=> seq_run[0])
      else $error("sequencer halted mid transfer");
   forward_a: assert property (
      data_space_wr[0] |=> unit_forward[0])
      else $error("data write not forwarded");
   reserved_a: assert property (
      wr && paddr == `DGLSC_OFS_GCTRL |=>
         gctrl_reg == $past(pwdata[`DGLSC_GCTRL_W-1:0]))
      else $error("control write not stored");
   busy_sources_a: assert property (
      unit_busy == 8'h00 |-> $past(unit_xfer_active) == 8'h00)
      else $error("busy clear during transfer");

   // Run bits of the last control write, kept for lockstep checks
   // Captured only on a landed write, so idle bus traffic cannot move it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwdata_q <= 8'h00;
      end
      else if (ce && wr && paddr == `DGLSC_OFS_GCTRL)
      begin
         pwdata_q <= pwdata[7:0];
      end
   end

   lockstep_hold_a: assert property (
      wr && paddr == `DGLSC_OFS_GCTRL |=> pwdata_q == $past(pwdata[7:0]))
      else $error("written run bits not held");

   group_fire_c: cover property (unit_update == 8'hff);
   seq_stop_c: cover property (seq_run[0] ##1 !seq_run[0]);
   irq_c: cover property (irq);
   err_c: cover property (pslverr && pready);
endmodule
`default_nettype wire

// File: logic/dglsc_pkg.sv
// Purpose: Types shared by the global load and sequencer control block
// Assumes: Constants live in dglsc_consts.svh
// Notes: Nothing here is imported; use dglsc_pkg::name
package dglsc_pkg;
   typedef enum logic [0:0] {
      DGLSC_SEQ_IDLE = 1'b0,
      DGLSC_SEQ_RUN = 1'b1
   } dglsc_seq_t;
endpackage

// File: test/dglsc_ctrl_tb_top.sv
// Purpose: Self-checking bench for the update-request and control block
// Assumes: Zero-wait APB slave, unit-side inputs driven on pclk
// Notes: Bench model holds request and control words as integers
`include "dglsc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dglsc_ctrl_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [`DGLSC_ADDR_W-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] man_m = 8'hff;
   logic [7:0] glb_m = 8'h00;
   logic [7:0] pend = 8'hff;
   logic [7:0] xfer = 8'h00;
   logic [7:0] dwr = 8'h00;
   logic [7:0] unit_update, unit_forward, seq_run, unit_busy;
   logic irq;
   logic [31:0] rd, lf;
   logic err;
   int error_cnt = 0;
   int num_checks = 0;
   int m_req, m_ctl, n;
   always #2.5 pclk = ~pclk;
   dglsc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .unit_manual_mode(man_m), .unit_global_mode(glb_m),
      .unit_data_pending(pend), .unit_xfer_active(xfer),
      .data_space_wr(dwr), .unit_update(unit_update),
      .unit_forward(unit_forward), .seq_run(seq_run),
      .unit_busy(unit_busy), .irq(irq));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return (x >> 1) ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
   endfunction
   task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Request held until pready is sampled high, then released
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends a wait for the answer
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #40000;
      error_cnt++;
      end_sim();
   end
   initial
   begin
      lf = 32'd70855;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b0, `DGLSC_OFS_UPD_REQ, 0);
      check("upd_rst", rd, 32'h0);
      apb(1'b0, `DGLSC_OFS_GCTRL, 0);
      check("ctl_rst", rd, 32'h0);
      // Pending data keeps requests logged; reserved bits written zero
      lf = lfsr(lf);
      m_req = (lf[7:0] | 8'h01);
      apb(1'b1, `DGLSC_OFS_UPD_REQ, {24'h000000, 8'(m_req)});
      apb(1'b0, `DGLSC_OFS_UPD_REQ, 0);
      check("upd_rw", rd, m_req);
      pend <= 8'h00;
      n = 0;
      while (unit_update === 8'h00 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      check("upd_fire", unit_update, m_req);
      apb(1'b0, `DGLSC_OFS_UPD_REQ, 0);
      check("upd_self_clr", rd, 32'h0);
      // Global-mode units wait for each other
      glb_m <= 8'h03;
      apb(1'b1, `DGLSC_OFS_UPD_REQ, 32'h1);
      apb(1'b0, `DGLSC_OFS_UPD_REQ, 0);
      check("glb_hold", rd, 32'h1);
      check("busy_wait", unit_busy[0], 1'b1);
      apb(1'b1, `DGLSC_OFS_UPD_REQ, 32'h3);
      n = 0;
      while (unit_update === 8'h00 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      check("glb_fire", unit_update, 32'h3);
      // One write starts several sequencers in the same cycle
      // Unit set-up order is kept outside this block
      lf = lfsr(lf);
      m_ctl = lf[7:0] | 8'h80;
      apb(1'b1, `DGLSC_OFS_GCTRL, m_ctl);
      n = 0;
      while (seq_run === 8'h00 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      check("seq_start", seq_run, m_ctl);
      @(posedge pclk);
      check("busy_run", unit_busy & seq_run, m_ctl);
      apb(1'b0, `DGLSC_OFS_GCTRL, 0);
      check("ctl_rw", rd, m_ctl);
      // Halt waits for the ongoing transfer
      xfer <= 8'hff;
      apb(1'b1, `DGLSC_OFS_GCTRL, 32'h0);
      repeat (4) @(posedge pclk);
      check("halt_delay", seq_run, m_ctl);
      apb(1'b0, `DGLSC_OFS_GSTAT, 0);
      check("gstat_busy", rd, 32'h1111_1111);
      xfer <= 8'h00;
      n = 0;
      while (unit_busy !== 8'h00 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      check("halted", seq_run, 32'h0);
      // Halt events are blocked until the gate bit opens
      apb(1'b1, `DGLSC_OFS_IRQ_EN, 32'hffff);
      repeat (2) @(posedge pclk);
      check("irq_gated", irq, 1'b0);
      apb(1'b1, `DGLSC_OFS_GCTRL, 32'h100);
      repeat (2) @(posedge pclk);
      check("irq_on", irq, 1'b1);
      apb(1'b0, `DGLSC_OFS_IRQ_STS, 0);
      check("irq_sts", rd, (m_ctl << 8) | m_req | 3);
      apb(1'b1, `DGLSC_OFS_IRQ_CLR, 32'hffff);
      repeat (2) @(posedge pclk);
      check("irq_clr", irq, 1'b0);
      apb(1'b0, 12'h090, 0);
      check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
      // Mid-run reset clears every register
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b0, `DGLSC_OFS_GCTRL, 0);
      check("ctl_rst2", rd, 32'h0);
      apb(1'b0, `DGLSC_OFS_IRQ_EN, 0);
      check("en_rst2", rd, 32'h0);
      // Fresh data only once the request bits read clear
      apb(1'b0, `DGLSC_OFS_UPD_REQ, 0);
      check("req_clear", rd, 32'h0);
      // Clock enable low freezes the forward pulse
      ce <= 1'b0;
      dwr <= 8'h5a;
      repeat (2) @(posedge pclk);
      check("ce_hold", unit_forward, 8'h00);
      ce <= 1'b1;
      dwr <= 8'h00;
      lf = lfsr(lf);
      @(posedge pclk);
      dwr <= lf[7:0] | 8'h01;
      @(posedge pclk);
      dwr <= 8'h00;
      @(posedge pclk);
      check("forward", unit_forward, lf[7:0] | 8'h01);
      end_sim();
   end
endmodule
`default_nettype wire
